/* File: hw/mss_dev.sv */
// Device end: supply monitor sequencing, resets, port selection, converter power
`timescale 1ns/1ps
`default_nettype none
`include "mss_cfg.svh"
module mss_dev
    import mss_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `MSS_SETTLE_CYC,
    parameter int unsigned BOOT_CYC = `MSS_BOOT_CYC,
    parameter int unsigned HWRST_CYC = `MSS_HWRST_CYC,
    parameter int unsigned SOFT_RESET_BIT_CYC = `MSS_SOFT_RESET_BIT_CYC
) (
    input wire logic SYS_CLK, // System clock, 100 MHz
    input wire logic RST, // Synchronous reset, active high
    input wire logic CE, // Clock enable, freezes all state when low
    input wire logic SUPPLY_OK, // Supply monitor comparator, high above threshold
    mss_link_if.dev LINK, // Pins and register channel to host
    output logic [`MSS_NADC-1:0] ADC_EN, // Converter power enables
    output logic DSP_RUN, // Signal processor running
    output logic PORT_SPI, // SPI is the active serial port
    output logic PORT_LOCKED, // Port selection locked
    output logic ACTIVE, // Device out of inactive state
    output logic FULL_FUNC, // All functions enabled
    output logic [1:0] POWER_MODE // Current power mode
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (SETTLE_CYC < 1 || BOOT_CYC < 1 || HWRST_CYC < 1 || SOFT_RESET_BIT_CYC < 1) begin : g_chk
        $error("mss_dev: cycle counts must be at least one");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int NP = 5;
    logic [NP-1:0] pin_s1;
    logic [NP-1:0] pin_s2;
    logic sel_q;
    wire [NP-1:0] pin_raw = {SUPPLY_OK, LINK.reset_pin_n, LINK.mode_pin_b, LINK.mode_pin_a,
        LINK.port_select_pin};

    // Two stages before any logic sees a pin
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pin_s1 <= 5'h09;
            pin_s2 <= 5'h09;
            sel_q <= 1'b1;
        end else if (CE) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            sel_q <= pin_s2[0];
        end
    end

    wire pin_sup = pin_s2[4];
    wire pin_rst_n = pin_s2[3];
    wire sel_fall = sel_q & ~pin_s2[0];
    wire [1:0] mode_now = pin_s2[2:1];

    // ----------------------------------------
    // Sequencer state and events
    // ----------------------------------------
    mss_state_t state;
    logic [31:0] cnt;
    mss_mode_t mode_q;
    logic [`MSS_DW-1:0] cfg;
    logic [`MSS_DW-1:0] cfg2;
    logic [`MSS_DW-1:0] lpt;
    logic [`MSS_DW-1:0] run;
    logic rdone;
    logic [1:0] tog;

    wire run_st = (state == MSS_RUN);
    wire norm = (mode_q == MSS_NORMAL);
    wire wr_ok = LINK.reg_wr & run_st & norm;
    wire settle_end = (state == MSS_SETTLE) && (cnt == 32'(SETTLE_CYC - 1));
    wire boot_end = (state == MSS_BOOT) && (cnt == 32'(BOOT_CYC - 1));
    wire hw_end = (state == MSS_HWRST) && pin_rst_n && (cnt >= 32'(HWRST_CYC));
    wire hw_glitch = (state == MSS_HWRST) && pin_rst_n && (cnt < 32'(HWRST_CYC));
    wire sw_end = (state == MSS_SOFT_RESET_BIT) && (cnt == 32'(SOFT_RESET_BIT_CYC - 1));
    wire hw_go = run_st && norm && !pin_rst_n;
    wire sw_go = wr_ok && (LINK.reg_addr == `MSS_A_CFG) && LINK.reg_wdata[`MSS_B_SOFT_RESET_BIT];
    wire wake = run_st && !norm && (mode_now == `MSS_MODE_NORMAL);
    wire full_def = boot_end | hw_end;
    wire done_evt = full_def | sw_end | wake;
    wire rdone_clr = wr_ok && (LINK.reg_addr == `MSS_A_STAT1) && LINK.reg_wdata[`MSS_B_RDONE];

    // Main sequence; a low supply overrides everything
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= MSS_OFF;
            cnt <= 32'h0000_0000;
        end else if (CE) begin
            if (!pin_sup) begin
                state <= MSS_OFF;
                cnt <= 32'h0000_0000;
            end else begin
                cnt <= cnt + 32'h0000_0001;
                case (state)
                    MSS_OFF: begin
                        state <= MSS_SETTLE;
                        cnt <= 32'h0000_0000;
                    end
                    MSS_SETTLE: if (settle_end) begin
                        state <= MSS_BOOT;
                        cnt <= 32'h0000_0000;
                    end
                    MSS_BOOT: if (boot_end) begin
                        state <= MSS_RUN;
                    end
                    MSS_RUN: if (hw_go) begin
                        state <= MSS_HWRST;
                        cnt <= 32'h0000_0001;
                    end else if (sw_go) begin
                        state <= MSS_SOFT_RESET_BIT;
                        cnt <= 32'h0000_0000;
                    end
                    MSS_HWRST: if (hw_end || hw_glitch) begin
                        state <= MSS_RUN;
                    end else if (cnt == 32'hFFFF_FFFF) begin
                        cnt <= cnt;
                    end
                    MSS_SOFT_RESET_BIT: if (sw_end) begin
                        state <= MSS_RUN;
                    end
                    default: state <= MSS_OFF;
                endcase
            end
        end
    end

    // Power mode is sampled only while running, so pins are read in normal mode first
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            mode_q <= MSS_NORMAL;
        end else if (CE) begin
            if (!pin_sup || state == MSS_BOOT) begin
                mode_q <= MSS_NORMAL;
            end else if (run_st && !hw_go && !sw_go) begin
                mode_q <= mss_mode_t'(mode_now);
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Power loss and hardware reset load all defaults, soft reset spares setup2 and threshold
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cfg <= `MSS_DEF_CFG;
            cfg2 <= `MSS_DEF_CFG2;
            lpt <= `MSS_DEF_LPT;
            run <= `MSS_DEF_RUN;
        end else if (CE) begin
            if (!pin_sup || full_def || state == MSS_HWRST) begin
                cfg <= `MSS_DEF_CFG;
                cfg2 <= `MSS_DEF_CFG2;
                lpt <= `MSS_DEF_LPT;
                run <= `MSS_DEF_RUN;
            end else if (sw_end) begin
                cfg <= `MSS_DEF_CFG;
                run <= `MSS_DEF_RUN;
            end else if (sw_go) begin
                cfg <= LINK.reg_wdata;
                run <= `MSS_DEF_RUN;
            end else if (wr_ok) begin
                if (LINK.reg_addr == `MSS_A_CFG) begin
                    cfg <= LINK.reg_wdata;
                end else if (LINK.reg_addr == `MSS_A_CFG2) begin
                    cfg2 <= LINK.reg_wdata;
                end else if (LINK.reg_addr == `MSS_A_LPT) begin
                    lpt <= LINK.reg_wdata;
                end else if (LINK.reg_addr == `MSS_A_RUN) begin
                    run <= LINK.reg_wdata;
                end
            end
        end
    end

    // Done flag: a completion event wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdone <= 1'b0;
        end else if (CE) begin
            if (!pin_sup || hw_go || sw_go) begin
                rdone <= 1'b0;
            end else if (done_evt) begin
                rdone <= 1'b1;
            end else if (rdone_clr) begin
                rdone <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Serial port selection
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PORT_SPI <= 1'b0;
            PORT_LOCKED <= 1'b0;
            tog <= 2'h0;
        end else if (CE) begin
            if (!pin_sup || full_def || state == MSS_HWRST) begin
                PORT_SPI <= 1'b0;
                PORT_LOCKED <= 1'b0;
                tog <= 2'h0;
            end else if (sw_end && !PORT_LOCKED) begin
                PORT_SPI <= 1'b0;
                tog <= 2'h0;
            end else if (wr_ok && LINK.reg_addr == `MSS_A_CFG2) begin
                if (PORT_SPI || LINK.reg_wdata[`MSS_B_LOCK]) begin
                    PORT_LOCKED <= 1'b1;
                end
            end else if (run_st && norm && !PORT_SPI && !PORT_LOCKED && sel_fall) begin
                if (tog == 2'(`MSS_SPI_TOGGLES - 1)) begin
                    PORT_SPI <= 1'b1;
                    tog <= 2'h0;
                end else begin
                    tog <= tog + 2'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [`MSS_DW-1:0] rd_mux;
    always_comb begin
        if (LINK.reg_addr == `MSS_A_CFG) begin
            rd_mux = cfg;
        end else if (LINK.reg_addr == `MSS_A_CFG2) begin
            rd_mux = cfg2;
        end else if (LINK.reg_addr == `MSS_A_LPT) begin
            rd_mux = lpt;
        end else if (LINK.reg_addr == `MSS_A_STAT1) begin
            rd_mux = {rdone, 15'h0000};
        end else if (LINK.reg_addr == `MSS_A_RUN) begin
            rd_mux = run;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            LINK.reg_rdata <= 16'h0000;
            LINK.reg_rvalid <= 1'b0;
            LINK.second_interrupt_out_n <= 1'b1;
            ADC_EN <= `MSS_ADC_OFF;
            DSP_RUN <= 1'b0;
            ACTIVE <= 1'b0;
            FULL_FUNC <= 1'b0;
            POWER_MODE <= `MSS_MODE_NORMAL;
        end else if (CE) begin
            LINK.reg_rvalid <= LINK.reg_rd & run_st & norm;
            if (LINK.reg_rd && run_st && norm) begin
                LINK.reg_rdata <= rd_mux;
            end
            LINK.second_interrupt_out_n <= ~rdone;
            if (!run_st) begin
                ADC_EN <= `MSS_ADC_OFF;
            end else if (norm) begin
                ADC_EN <= `MSS_ADC_ALL;
            end else if (mode_q == MSS_MEAN) begin
                ADC_EN <= `MSS_ADC_CUR;
            end else begin
                ADC_EN <= `MSS_ADC_OFF;
            end
            DSP_RUN <= run_st & norm & run[`MSS_B_RUN];
            ACTIVE <= pin_sup && state != MSS_OFF && state != MSS_SETTLE;
            FULL_FUNC <= run_st;
            POWER_MODE <= mode_q;
        end
    end

endmodule : mss_dev
`default_nettype wire

/* File: shared/mss_cfg.svh */
// Constants of the metering start-up and reset sequencer
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define MSS_CLK_MHZ 100
`define MSS_SETTLE_MS 26
`define MSS_FULL_MS 40
`define MSS_HWRST_US 10
`define MSS_SOFT_RESET_BIT_CYC 16
`define MSS_TOG_CYC 8
`define MSS_HOLD_PAD 4
`define MSS_SETTLE_CYC (`MSS_SETTLE_MS * 1000 * `MSS_CLK_MHZ)
`define MSS_BOOT_CYC ((`MSS_FULL_MS - `MSS_SETTLE_MS) * 1000 * `MSS_CLK_MHZ)
`define MSS_HWRST_CYC (`MSS_HWRST_US * `MSS_CLK_MHZ)

// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define MSS_AW 3
`define MSS_DW 16
`define MSS_A_CFG 3'h0
`define MSS_A_CFG2 3'h1
`define MSS_A_LPT 3'h2
`define MSS_A_STAT1 3'h3
`define MSS_A_RUN 3'h4
`define MSS_B_SOFT_RESET_BIT 7
`define MSS_B_LOCK 1
`define MSS_B_RDONE 15
`define MSS_B_RUN 0
`define MSS_DEF_CFG 16'h0000
`define MSS_DEF_CFG2 16'h0000
`define MSS_DEF_LPT 16'h0000
`define MSS_DEF_RUN 16'h0000
`define MSS_RUN_GO 16'h0001
`define MSS_RDONE_W 16'h8000
`define MSS_SPI_TOGGLES 3

// ----------------------------------------
// Converters: three currents, neutral, three voltages
// ----------------------------------------
`define MSS_NADC 7
`define MSS_ADC_ALL 7'h7F
`define MSS_ADC_CUR 7'h07
`define MSS_ADC_OFF 7'h00
`define MSS_MODE_NORMAL 2'h1

`endif

/* File: shared/mss_pkg.sv */
// Types of the metering start-up and reset sequencer
package mss_pkg;
    typedef enum logic [2:0] {MSS_OFF, MSS_SETTLE, MSS_BOOT, MSS_RUN, MSS_HWRST, MSS_SOFT_RESET_BIT} mss_state_t;
    typedef enum logic [1:0] {MSS_MEAN, MSS_NORMAL, MSS_WATCH, MSS_SLEEP} mss_mode_t;
    typedef enum logic [2:0] {MSS_H_IDLE, MSS_H_RSTLOW, MSS_H_TOGHI, MSS_H_TOGLO, MSS_H_ACK} mss_hstate_t;
endpackage : mss_pkg

/* File: shared/mss_link_if.sv */
// Pins and register channel between host and metering device
`timescale 1ns/1ps
`default_nettype none
`include "mss_cfg.svh"
interface mss_link_if;
    logic reset_pin_n;
    logic mode_pin_a;
    logic mode_pin_b;
    logic port_select_pin;
    logic second_interrupt_out_n;
    logic reg_wr;
    logic reg_rd;
    logic [`MSS_AW-1:0] reg_addr;
    logic [`MSS_DW-1:0] reg_wdata;
    logic [`MSS_DW-1:0] reg_rdata;
    logic reg_rvalid;
    modport dev (input reset_pin_n, mode_pin_a, mode_pin_b, port_select_pin, reg_wr, reg_rd,
        reg_addr, reg_wdata, output second_interrupt_out_n, reg_rdata, reg_rvalid);
    modport host (output reset_pin_n, mode_pin_a, mode_pin_b, port_select_pin, reg_wr, reg_rd,
        reg_addr, reg_wdata, input second_interrupt_out_n, reg_rdata, reg_rvalid);
endinterface : mss_link_if
`default_nettype wire

/* File: hw/mss_host.sv */
// Host end: drives reset, mode and select pins and the register channel
`timescale 1ns/1ps
`default_nettype none
`include "mss_cfg.svh"
module mss_host
    import mss_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `MSS_HWRST_CYC + `MSS_HOLD_PAD,
    parameter int unsigned TOG_CYC = `MSS_TOG_CYC
) (
    input wire logic SYS_CLK, // System clock, 100 MHz
    input wire logic RST, // Synchronous reset, active high
    input wire logic CE, // Clock enable, freezes all state when low
    input wire logic [1:0] CMD_MODE, // Wanted power mode, {pin b, pin a}
    input wire logic CMD_HWRST, // Pulse: start a hardware reset
    input wire logic CMD_SPI, // Pulse: run the SPI selection sequence
    input wire logic SPI_WANTED, // Repeat SPI selection after each hardware reset
    input wire logic CMD_WR, // Pulse: register write
    input wire logic CMD_RD, // Pulse: register read
    input wire logic [`MSS_AW-1:0] CMD_ADDR, // Register index
    input wire logic [`MSS_DW-1:0] CMD_WDATA, // Write data
    output logic [`MSS_DW-1:0] RDATA, // Read data
    output logic RVALID, // Pulse: read data valid
    output logic DONE_SEEN, // Pulse: done interrupt seen and cleared
    output logic BUSY, // Sequence in progress, commands ignored
    mss_link_if.host LINK // Pins and register channel to device
);

    if (HOLD_CYC < `MSS_HWRST_CYC || TOG_CYC < 3) begin : g_chk
        $error("mss_host: hold or toggle time too short");
    end

    mss_hstate_t st;
    logic [31:0] cnt;
    logic [1:0] nfall;
    logic irq_s1;
    logic irq_s2;
    logic armed;
    wire idle = (st == MSS_H_IDLE);
    wire ack_go = idle && !irq_s2 && armed && !CMD_WR && !CMD_RD;
    wire tog_end = (cnt == 32'(TOG_CYC - 1));

    // Interrupt pin synchroniser
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irq_s1 <= 1'b1;
            irq_s2 <= 1'b1;
        end else if (CE) begin
            irq_s1 <= LINK.second_interrupt_out_n;
            irq_s2 <= irq_s1;
        end
    end

    // Pin sequencing
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st <= MSS_H_IDLE;
            cnt <= 32'h0000_0000;
            nfall <= 2'h0;
            LINK.reset_pin_n <= 1'b1;
            LINK.mode_pin_a <= 1'b1;
            LINK.mode_pin_b <= 1'b0;
            LINK.port_select_pin <= 1'b1;
        end else if (CE) begin
            cnt <= cnt + 32'h0000_0001;
            case (st)
                MSS_H_IDLE: begin
                    LINK.mode_pin_a <= CMD_MODE[0];
                    LINK.mode_pin_b <= CMD_MODE[1];
                    cnt <= 32'h0000_0000;
                    nfall <= 2'h0;
                    if (CMD_HWRST) begin
                        st <= MSS_H_RSTLOW;
                        LINK.reset_pin_n <= 1'b0;
                    end else if (CMD_SPI) begin
                        st <= MSS_H_TOGHI;
                    end
                end
                MSS_H_RSTLOW: if (cnt == 32'(HOLD_CYC - 1)) begin
                    LINK.reset_pin_n <= 1'b1;
                    cnt <= 32'h0000_0000;
                    st <= SPI_WANTED ? MSS_H_TOGHI : MSS_H_IDLE;
                end
                MSS_H_TOGHI: if (tog_end) begin
                    LINK.port_select_pin <= 1'b0;
                    cnt <= 32'h0000_0000;
                    st <= MSS_H_TOGLO;
                end
                MSS_H_TOGLO: if (tog_end) begin
                    LINK.port_select_pin <= 1'b1;
                    cnt <= 32'h0000_0000;
                    nfall <= nfall + 2'h1;
                    st <= (nfall == 2'(`MSS_SPI_TOGGLES - 1)) ? MSS_H_IDLE : MSS_H_TOGHI;
                end
                default: st <= MSS_H_IDLE;
            endcase
        end
    end

    // Register channel and done acknowledge
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            LINK.reg_wr <= 1'b0;
            LINK.reg_rd <= 1'b0;
            LINK.reg_addr <= `MSS_A_CFG;
            LINK.reg_wdata <= 16'h0000;
            armed <= 1'b1;
            DONE_SEEN <= 1'b0;
            RDATA <= 16'h0000;
            RVALID <= 1'b0;
            BUSY <= 1'b0;
        end else if (CE) begin
            LINK.reg_wr <= 1'b0;
            LINK.reg_rd <= 1'b0;
            DONE_SEEN <= ack_go;
            RVALID <= LINK.reg_rvalid;
            BUSY <= !idle;
            if (LINK.reg_rvalid) begin
                RDATA <= LINK.reg_rdata;
            end
            if (irq_s2) begin
                armed <= 1'b1;
            end
            if (ack_go) begin
                LINK.reg_wr <= 1'b1;
                LINK.reg_addr <= `MSS_A_STAT1;
                LINK.reg_wdata <= `MSS_RDONE_W;
                armed <= 1'b0;
            end else if (idle && (CMD_WR || CMD_RD)) begin
                LINK.reg_wr <= CMD_WR;
                LINK.reg_rd <= CMD_RD & ~CMD_WR;
                LINK.reg_addr <= CMD_ADDR;
                LINK.reg_wdata <= CMD_WDATA;
            end
        end
    end

endmodule : mss_host
`default_nettype wire

/* File: tb/mss_link_sva.sv */
// Assertions on the pins and register channel between host and device
`timescale 1ns/1ps
`default_nettype none
`include "mss_cfg.svh"
module mss_link_sva (
    input wire logic SYS_CLK, // System clock
    input wire logic RST, // Synchronous reset, active high
    input wire logic reset_pin_n, // Reset pin, low active
    input wire logic mode_pin_a, // Mode pin a
    input wire logic mode_pin_b, // Mode pin b
    input wire logic second_interrupt_out_n, // Done interrupt, low active
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [`MSS_AW-1:0] reg_addr, // Register index
    input wire logic [`MSS_DW-1:0] reg_wdata, // Write data
    input wire logic [`MSS_DW-1:0] reg_rdata, // Read data
    input wire logic reg_rvalid // Read data valid
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    // ----------------------------------------
    // Register channel and done flag
    // ----------------------------------------
    wire normal = mode_pin_a && !mode_pin_b;
    wire stat_wr = reg_wr && reg_addr == `MSS_A_STAT1;
    chk_read_answer_time: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read data without a read strobe");
    chk_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_status_mirror: assert property (reg_rvalid && $past(reg_addr) == `MSS_A_STAT1
        |-> reg_rdata == {~second_interrupt_out_n, 15'h0000})
        else $error("status read does not match the done interrupt");
    chk_clear_releases_irq: assert property (stat_wr && reg_wdata[15] && normal
        && reset_pin_n && !second_interrupt_out_n |-> ##2 second_interrupt_out_n)
        else $error("done interrupt not released by status write");
    chk_keep_without_bit: assert property (stat_wr && !reg_wdata[15] && reset_pin_n
        && !$past(reg_wr) && !second_interrupt_out_n |=> !second_interrupt_out_n [*2])
        else $error("done interrupt changed by status write without bit 15");
    chk_reset_clears_done: assert property ($fell(reset_pin_n) && normal
        |-> ##[1:6] second_interrupt_out_n)
        else $error("done interrupt still low during hardware reset");
    chk_no_done_in_reset: assert property ($fell(second_interrupt_out_n)
        |-> reset_pin_n && $past(reset_pin_n))
        else $error("done raised while reset pin low");
    chk_soft_reset_window: assert property (reg_wr && reg_addr == `MSS_A_CFG
        && reg_wdata[7] && normal && second_interrupt_out_n |=> second_interrupt_out_n [*3])
        else $error("done raised inside soft reset");
    // Main scenarios seen
    cover property (reg_rvalid && $past(reg_addr) == `MSS_A_STAT1);
    cover property (stat_wr && reg_wdata[15]);
    cover property ($fell(reset_pin_n) && normal);
endmodule : mss_link_sva
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench: host and device ends joined across the link interface
`timescale 1ns/1ps
`default_nettype none
`include "mss_cfg.svh"
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic spi_wanted = 1'b0;
    logic supply_ok = 1'b0;
    logic [1:0] cmd_mode = 2'h1;
    logic cmd_hwrst = 1'b0;
    logic cmd_spi = 1'b0;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [2:0] cmd_addr = 3'h0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [15:0] rdata;
    logic rvalid;
    logic busy;
    logic irq_n;
    logic [6:0] adc_en;
    logic dsp_run, port_spi, port_locked, active, full_func;
    logic [1:0] power_mode;
    int n_errors = 0;
    int comparisons = 0;
    mss_link_if link ();
    always_comb irq_n = link.second_interrupt_out_n;
    // ----------------------------------------
    // Ends, checker and clock
    // ----------------------------------------
    mss_dev #(.SETTLE_CYC(20), .BOOT_CYC(20), .HWRST_CYC(10), .SOFT_RESET_BIT_CYC(4)) u_mss_dev (
        .SYS_CLK(sys_clk), .RST(rst), .CE(ce), .SUPPLY_OK(supply_ok), .LINK(link),
        .ADC_EN(adc_en), .DSP_RUN(dsp_run), .PORT_SPI(port_spi), .PORT_LOCKED(port_locked),
        .ACTIVE(active), .FULL_FUNC(full_func), .POWER_MODE(power_mode));
    mss_host #(.HOLD_CYC(14)) u_mss_host (
        .SYS_CLK(sys_clk), .RST(rst), .CE(ce), .CMD_MODE(cmd_mode), .CMD_HWRST(cmd_hwrst),
        .CMD_SPI(cmd_spi), .SPI_WANTED(spi_wanted), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
        .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RDATA(rdata), .RVALID(rvalid),
        .DONE_SEEN(), .BUSY(busy), .LINK(link));
    mss_link_sva u_mss_link_sva (.SYS_CLK(sys_clk), .RST(rst), .reset_pin_n(link.reset_pin_n),
        .mode_pin_a(link.mode_pin_a), .mode_pin_b(link.mode_pin_b),
        .second_interrupt_out_n(link.second_interrupt_out_n), .reg_wr(link.reg_wr),
        .reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
        .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_for(ref logic sig, input logic lvl, input string what);
        int k;
        k = 0;
        while (sig !== lvl && k < 300) begin
            tick(1);
            k++;
        end
        check(what, 16'(lvl), 16'(sig));
    endtask : wait_for
    task automatic pulse(ref logic sig);
        wait_for(busy, 1'b0, "busy");
        sig = 1'b1;
        tick(1);
        sig = 1'b0;
        tick(2);
    endtask : pulse
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        cmd_addr = a;
        cmd_wdata = d;
        pulse(cmd_wr);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string what);
        cmd_addr = a;
        wait_for(busy, 1'b0, "busy");
        cmd_rd = 1'b1;
        tick(1);
        cmd_rd = 1'b0;
        wait_for(rvalid, 1'b1, "rvalid");
        check(what, exp, rdata);
    endtask : rd
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // Watchdog against a hang
    initial begin
        #20000;
        n_errors++;
        close_out();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        tick(2);
        rst = 1'b0;
        supply_ok = 1'b1;
        tick(12);
        check("active early", 16'h0000, 16'(active));
        tick(20);
        check("active late", 16'h0001, 16'(active));
        check("full early", 16'h0000, 16'(full_func));
        wait_for(irq_n, 1'b0, "done irq");
        check("full", 16'h0001, 16'(full_func));
        check("mode", 16'h0001, 16'(power_mode));
        check("adc", 16'h007F, 16'(adc_en));
        check("spi", 16'h0000, 16'(port_spi));
        check("dsp", 16'h0000, 16'(dsp_run));
        tick(10);
        check("irq released", 16'h0001, 16'(irq_n));
        rd(`MSS_A_STAT1, 16'h0000, "status");
        rd(3'h7, 16'h0000, "unmapped");
        $display("test power-up finished");
        wr(`MSS_A_CFG2, 16'h0002);
        wr(`MSS_A_LPT, 16'h1234);
        pulse(cmd_spi);
        wait_for(busy, 1'b0, "busy");
        tick(4);
        check("spi after lock", 16'h0000, 16'(port_spi));
        check("locked", 16'h0001, 16'(port_locked));
        wr(`MSS_A_RUN, `MSS_RUN_GO);
        check("dsp run", 16'h0001, 16'(dsp_run));
        wr(`MSS_A_CFG, 16'h0080);
        wait_for(irq_n, 1'b0, "soft done");
        wr(`MSS_A_STAT1, 16'h0000);
        tick(10);
        check("irq acked", 16'h0001, 16'(irq_n));
        rd(`MSS_A_CFG, 16'h0000, "cfg");
        rd(`MSS_A_RUN, 16'h0000, "run");
        rd(`MSS_A_CFG2, 16'h0002, "setup2 kept");
        rd(`MSS_A_LPT, 16'h1234, "threshold kept");
        check("lock kept", 16'h0001, 16'(port_locked));
        $display("test soft reset finished");
        pulse(cmd_hwrst);
        wait_for(irq_n, 1'b0, "hard done");
        rd(`MSS_A_CFG2, 16'h0000, "setup2 default");
        rd(`MSS_A_LPT, 16'h0000, "threshold default");
        check("unlocked", 16'h0000, 16'(port_locked));
        pulse(cmd_spi);
        wait_for(busy, 1'b0, "busy");
        tick(4);
        check("spi", 16'h0001, 16'(port_spi));
        wr(`MSS_A_CFG2, 16'h0000);
        check("spi locked", 16'h0001, 16'(port_locked));
        $display("test port select finished");
        cmd_mode = 2'h0;
        tick(10);
        check("adc mean", 16'h0007, 16'(adc_en));
        check("spi mean", 16'h0001, 16'(port_spi));
        pulse(cmd_hwrst);
        tick(20);
        check("spi kept", 16'h0001, 16'(port_spi));
        check("lock kept", 16'h0001, 16'(port_locked));
        cmd_mode = 2'h3;
        tick(10);
        check("adc sleep", 16'h0000, 16'(adc_en));
        cmd_mode = 2'h1;
        wait_for(irq_n, 1'b0, "normal done");
        check("adc normal", 16'h007F, 16'(adc_en));
        check("spi normal", 16'h0001, 16'(port_spi));
        tick(10);
        pulse(cmd_hwrst);
        wait_for(irq_n, 1'b0, "reset done");
        check("two-wire", 16'h0000, 16'(port_spi));
        spi_wanted = 1'b1;
        pulse(cmd_hwrst);
        tick(70);
        check("spi again", 16'h0001, 16'(port_spi));
        $display("test power modes finished");
        ce = 1'b0;
        supply_ok = 1'b0;
        tick(6);
        check("frozen", 16'h0001, 16'(active));
        ce = 1'b1;
        tick(6);
        check("inactive", 16'h0000, 16'(active));
        check("adc off", 16'h0000, 16'(adc_en));
        $display("test supply loss finished");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
